// ===== dv/host_link_model.sv
// host model acting as serial controller on the link pins of the frame port
// assumes mosi is sampled on rising link clock and miso shifts after that edge
`timescale 1ns/1ps
module host_link_model (
  output logic      o_clk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  logic [15:0] rd_q [$];    // miso words of the last frame, header slot first
  realtime     half = 6.0;  // 12 ns link clock unless a test speeds it up
  initial begin
    o_clk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // -------------------------------------------------------------------------
  // one frame: header then n words, clock standing low between words
  // -------------------------------------------------------------------------
  task automatic frame(input logic [15:0] hdr, input int n, input logic [15:0] w,
                       input int gap);
    logic [15:0] v;
    logic [15:0] r;
    rd_q.delete();
    #3.7 o_cs_n = 1'b0;  // odd offset keeps the two clocks out of phase
    for (int k = 0; k <= n; k++) begin
      v = (k == 0) ? hdr : w;
      for (int i = 15; i >= 0; i--) begin
        o_mosi = v[i];
        #(half) r = {r[14:0], i_miso};
        o_clk = 1'b1;
        #(half) o_clk = 1'b0;
      end
      rd_q.push_back(r);
      #(gap);
    end
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;  // released line shows no stale bit
    #(gap);
  endtask
endmodule

// ===== dv/mac_host_fifo_port_tb.sv
// self-checking bench for the host frame port: link access, rx/tx ports, flags
// assumes the host model owns the link pins; the fifo side is driven here
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module mac_host_fifo_port_tb;
  import mac_host_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  ev = '0;  // event pulses towards the port
  logic        head_avail = 1'b1, eof = 1'b0, frames = 1'b0, whole = 1'b0;
  logic [10:0] head_len = 11'h003;
  logic [15:0] rx_word = 16'haabb, gap_len = 16'h0003, txw;
  logic [6:0]  rx_lvl = 7'h00;
  logic [13:0] tx_free = 14'h0fff, tx_buf = 14'h0000;
  logic        lclk, cs_n, mosi, miso, rx_pop, rx_ready, tx_push, tx_last, tx_last_odd;
  logic        tx_abort, tx_start, tx_halt, fwd, low_first, operation_error_summary, irq, lastodd, oe_n, gap_drop;
  logic [15:0] tx_word;
  int          failures = 0, comparisons = 0, pops = 0, pushes = 0, aborts = 0, drops = 0;
  always #25 sys_clk = ~sys_clk;
  host_link_model u_host (.o_clk(lclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
  mac_host_fifo_port u_dut (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_link_clk(lclk), .i_link_cs_n(cs_n),
    .i_link_mosi(mosi), .o_link_miso(miso), .o_link_miso_oe_n(oe_n),
    .i_rx_head_avail(head_avail), .i_rx_head_len(head_len), .i_rx_word(rx_word),
    .i_rx_level(rx_lvl), .i_rx_eof_seen(eof), .i_rx_frames_avail(frames),
    .i_rx_gap_strobe(ev[0]), .i_rx_gap_len(gap_len), .i_rx_len_ecc_err(ev[6]),
    .i_rx_fifo_flush(ev[8]), .i_tx_free(tx_free), .i_tx_buffered(tx_buf),
    .i_tx_frame_whole(whole), .i_tx_underrun(ev[1]), .i_tx_len_ecc_err(ev[5]),
    .i_tx_fifo_flush(ev[7]), .i_link_crc_err(ev[2]), .i_hdr_parity_err(ev[3]),
    .i_ctrl_mismatch_err(ev[4]), .o_rx_pop(rx_pop), .o_rx_gap_drop(gap_drop),
    .o_rx_ready(rx_ready), .o_tx_push(tx_push), .o_tx_word(tx_word),
    .o_tx_last(tx_last), .o_tx_last_odd(tx_last_odd), .o_tx_abort(tx_abort),
    .o_tx_start(tx_start), .o_tx_halt(tx_halt), .o_fwd_unknown_to_host(fwd),
    .o_rx_low_first(low_first), .o_operation_error_summary(operation_error_summary), .o_err_irq(irq));
  // fifo side: a pop advances the head word; pushes and aborts are counted
  always @(posedge sys_clk) begin
    if (rx_pop === 1'b1) begin
      rx_word <= rx_word + 16'h2222;
      pops++;
    end
    if (tx_push === 1'b1) begin
      pushes++;
      txw = tx_word;
      if (tx_last === 1'b1) lastodd = tx_last_odd;
    end
    if (tx_abort === 1'b1) aborts++;
    if (gap_drop === 1'b1) drops++;
  end
  // -------------------------------------------------------------------------
  // link access helpers
  // -------------------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input int n);
    u_host.frame({8'h00, a}, n + 1, 16'h0000, 300);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.frame({8'h80, a}, 1, d, 300);
  endtask
  function automatic logic [15:0] got(input int i);
    return u_host.rd_q[i + 2];
  endfunction
  task automatic pulse(input int k);
    @(posedge sys_clk) ev[k] <= 1'b1;
    @(posedge sys_clk) ev[k] <= 1'b0;
  endtask
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0]  offs [9] = '{OFF_ERR_FLAGS, OFF_ERR_MASK, OFF_RX_LEVEL, OFF_TX_FREE,
                              OFF_TX_START, OFF_HOST_CFG, 8'h20, OFF_RX_GAP, OFF_TX_LEN};
    logic [15:0] exps [9] = '{16'h0000, 16'h0000, 16'h0010, 16'h0fff, 16'h0004,
                              16'h0000, 16'h0000, 16'h000a, 16'h0000};
    foreach (offs[i]) begin
      rd(offs[i], 1);
      `CHK(got(0), exps[i])
    end
    `CHK(oe_n, 1'b1)
  endtask
  task automatic t_rx();
    @(posedge sys_clk) head_avail <= 1'b0;
    rd(OFF_RX_LEN, 1);
    `CHK(got(0), 16'h0000)
    @(posedge sys_clk) head_avail <= 1'b1;
    rd(OFF_RX_DATA, 1);
    `CHK(got(0), 16'h0000)
    rd(OFF_RX_LEN, 1);
    `CHK(got(0), 16'h0003)
    rd(OFF_RX_DATA, 3);
    `CHK(got(0), 16'haabb)
    `CHK(got(1), 16'hcc00)
    `CHK(got(2), 16'h0000)
    `CHK(pops, 2)
  endtask
  task automatic t_tx();
    rd(OFF_TX_FREE, 1);
    `CHK(got(0), 16'h0fff)
    wr(OFF_TX_LEN, 16'h0005);
    u_host.frame({8'h80, OFF_TX_DATA}, 4, 16'h1234, 300);
    `CHK(pushes, 3)
    `CHK({lastodd, txw}, 17'h11234)
    @(posedge sys_clk) tx_free <= 14'h0000;
    wr(OFF_TX_LEN, 16'h0004);
    wr(OFF_TX_DATA, 16'h5678);
    `CHK(aborts, 1)
    rd(OFF_ERR_FLAGS, 1);
    `CHK(got(0), 16'h0008)
    wr(OFF_ERR_FLAGS, 16'h0008);
    @(posedge sys_clk) tx_free <= 14'h0fff;
    wr(OFF_TX_LEN, 16'h0004);
    u_host.frame({8'h80, OFF_TX_DATA}, 2, 16'h5678, 300);
    `CHK(pushes, 5)
    `CHK(lastodd, 1'b0)
  endtask
  task automatic t_levels();
    // store-and-forward: levels are ignored, whole frames decide
    @(posedge sys_clk) frames <= 1'b1;
    tx_buf <= 14'h0005;
    repeat (2) @(posedge sys_clk);
    `CHK({rx_ready, tx_start}, 2'b10)
    frames <= 1'b0;
    tx_buf <= 14'h0000;
    wr(OFF_HOST_CFG, 16'h0027);
    wr(OFF_RX_LEVEL, 16'h0004);
    wr(OFF_TX_START, 16'h0000);
    @(posedge sys_clk) rx_lvl <= 7'h03;
    repeat (2) @(posedge sys_clk);
    `CHK({fwd, low_first, rx_ready, tx_start}, 4'b1100)
    @(posedge sys_clk) rx_lvl <= 7'h04;
    tx_buf <= 14'h0001;
    repeat (2) @(posedge sys_clk);
    `CHK({rx_ready, tx_start}, 2'b11)
  endtask
  task automatic t_errors();
    int bitpos [7] = '{5, 4, 2, 2, 2, 1, 0};
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      rd(OFF_ERR_FLAGS, 1);
      `CHK(got(0), 16'h0001 << bitpos[k])
      `CHK({operation_error_summary, irq}, 2'b11)
      wr(OFF_ERR_MASK, 16'h0001 << bitpos[k]);
      `CHK(irq, 1'b0)
      wr(OFF_ERR_FLAGS, 16'h0000);
      `CHK(operation_error_summary, 1'b1)
      wr(OFF_ERR_FLAGS, 16'h0001 << bitpos[k]);
      wr(OFF_ERR_MASK, 16'h0000);
      `CHK(operation_error_summary, 1'b0)
    end
    `CHK(drops, 1)
    `CHK({tx_halt, tx_start}, 2'b10)
    rd(OFF_RX_LEN, 1);
    `CHK(got(0), 16'h0000)
    pulse(7);
    pulse(8);
    rd(OFF_RX_LEN, 1);
    `CHK({tx_halt, got(0)}, 17'h00003)
  endtask
  task automatic t_fault();
    u_host.half = 2.0;
    u_host.frame({8'h80, OFF_ERR_MASK}, 3, 16'h0000, 0);
    u_host.half = 6.0;
    repeat (10) @(posedge sys_clk);
    rd(OFF_ERR_FLAGS, 1);
    `CHK(got(0), 16'h4000)
    wr(OFF_ERR_FLAGS, 16'h4000);
    rd(OFF_ERR_FLAGS, 1);
    `CHK(got(0), 16'h0000)
  endtask
  task automatic print_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence after three reset cycles
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_rx();
    t_tx();
    t_levels();
    t_errors();
    t_fault();
    print_verdict();
  end
  // watchdog: the tests need well under half of this span
  initial begin
    #1ms;
    failures++;
    print_verdict();
  end
endmodule

// ===== rtl/link_engine.sv
// serial link engine: shifts header and data words on the link clock
// assumes the link clock runs only while chip select is low
`timescale 1ns/1ps
module link_engine
  import mac_host_pkg::*;
(
  input  wire logic  i_link_clk,
  input  wire logic  i_rst,
  input  wire logic  i_cs_n,
  input  wire logic  i_mosi,
  output logic       o_miso,
  output logic       o_miso_oe_n,
  spi_xfer_if.link   x
);

  typedef struct packed {
    logic [3:0]  bit_cnt;
    logic        hdr_done;
    logic        is_write;
    logic [15:0] shin;
    logic [15:0] shout;
    logic        oe_n;
  } frame_t;

  typedef struct packed {
    logic        req_tgl;
    logic        flt_tgl;
    logic        ack_s1;
    logic        ack_s2;
    logic        write;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } hs_t;

  frame_t      f_q, f_d;
  hs_t         h_q, h_d;
  logic [15:0] word;
  logic        frame_clr;

  // ---------------------------------------------------------------------------
  // word engine
  // ---------------------------------------------------------------------------
  // the address stays fixed over a burst so data ports stream word after word
  always_comb begin
    f_d         = f_q;
    h_d         = h_q;
    word        = {f_q.shin[14:0], i_mosi};
    h_d.ack_s1  = x.ack_tgl;
    h_d.ack_s2  = h_q.ack_s1;
    f_d.oe_n    = 1'b0;
    f_d.shin    = word;
    f_d.bit_cnt = f_q.bit_cnt + 4'h1;
    f_d.shout   = {f_q.shout[14:0], 1'b0};
    if (f_q.bit_cnt == WORD_LAST_BIT) begin
      if (!f_q.hdr_done) begin
        f_d.hdr_done = 1'b1;
        f_d.is_write = word[HDR_WRITE_BIT];
        h_d.write    = word[HDR_WRITE_BIT];
        h_d.addr     = word[7:0];
        // reads fetch during the turnaround word, which shifts out zero
        if (!word[HDR_WRITE_BIT]) begin
          h_d.req_tgl = ~h_q.req_tgl;
        end
      end else if (h_q.ack_s2 != h_q.req_tgl) begin
        // previous word not yet answered: link clocked too fast
        h_d.flt_tgl = ~h_q.flt_tgl;
      end else if (f_q.is_write) begin
        h_d.wdata   = word;
        h_d.req_tgl = ~h_q.req_tgl;
      end else begin
        f_d.shout   = x.rdata;
        h_d.req_tgl = ~h_q.req_tgl;
      end
    end
  end

  // frame state is cleared by chip select itself, since no edge follows a frame
  assign frame_clr = i_rst | i_cs_n;

  always_ff @(posedge i_link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      f_q      <= '0;
      f_q.oe_n <= 1'b1;
    end else begin
      f_q <= f_d;
    end
  end

  // toggles survive between frames; only the system reset clears them
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  assign x.req_tgl   = h_q.req_tgl;
  assign x.req_write = h_q.write;
  assign x.req_addr  = h_q.addr;
  assign x.req_wdata = h_q.wdata;
  assign x.fault_tgl = h_q.flt_tgl;
  assign o_miso      = f_q.shout[15];
  assign o_miso_oe_n = f_q.oe_n;

endmodule

// ===== rtl/mac_host_fifo_port.sv
// host frame port: error flags, receive and transmit frame ports, thresholds
// assumes fifo, filter and clear units of the mac share i_sys_clk
//
// Notes on behaviour
// - read fault flag 14 on overrun, W1C
// - short gap frame dropped, flag 5
// - underrun flag only in tx cut-through; halts
// - overflow: flag 3, discard frame, wait SOF
// - tx fifo over one frame, abort spares sender
// - link error flag 2 from three causes
// - tx size ECC: flag 1, halt until flush
// - rx size ECC: flag 0, withhold until flush
// - mask bit per flag, reset zero
// - 11-bit head frame length, read first
// - data read pops two bytes, first high
// - no data after frame until length reread
// - burst reads through single data address
// - rx ready at 7-bit level in cut-through
// - tx byte count limits writes until rewritten
// - each write appends two bytes, odd last
// - 14-bit free space, resets to 0xfff
// - tx cut-through start at 1..26 level
// - config bit 5 forwards unknown destinations
// - summary error bit when any flag set
// - mask gates flags onto interrupt
`timescale 1ns/1ps
module mac_host_fifo_port
  import mac_host_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_link_clk,
  input  wire logic        i_link_cs_n,
  input  wire logic        i_link_mosi,
  output logic             o_link_miso,
  output logic             o_link_miso_oe_n,
  input  wire logic        i_rx_head_avail,
  input  wire logic [10:0] i_rx_head_len,
  input  wire logic [15:0] i_rx_word,
  input  wire logic [6:0]  i_rx_level,
  input  wire logic        i_rx_eof_seen,
  input  wire logic        i_rx_frames_avail,
  input  wire logic        i_rx_gap_strobe,
  input  wire logic [15:0] i_rx_gap_len,
  input  wire logic        i_rx_len_ecc_err,
  input  wire logic        i_rx_fifo_flush,
  input  wire logic [13:0] i_tx_free,
  input  wire logic [13:0] i_tx_buffered,
  input  wire logic        i_tx_frame_whole,
  input  wire logic        i_tx_underrun,
  input  wire logic        i_tx_len_ecc_err,
  input  wire logic        i_tx_fifo_flush,
  input  wire logic        i_link_crc_err,
  input  wire logic        i_hdr_parity_err,
  input  wire logic        i_ctrl_mismatch_err,
  output logic             o_rx_pop,
  output logic             o_rx_gap_drop,
  output logic             o_rx_ready,
  output logic             o_tx_push,
  output logic [15:0]      o_tx_word,
  output logic             o_tx_last,
  output logic             o_tx_last_odd,
  output logic             o_tx_abort,
  output logic             o_tx_start,
  output logic             o_tx_halt,
  output logic             o_fwd_unknown_to_host,
  output logic             o_rx_low_first,
  output logic             o_operation_error_summary,
  output logic             o_err_irq
);

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_seen;
    logic        flt_s1;
    logic        flt_s2;
    logic        flt_seen;
    logic        ack;
    logic [15:0] rdata;
    logic [15:0] flags;
    logic [15:0] mask;
    logic [15:0] cfg;
    logic [15:0] rx_gap;
    logic [6:0]  rx_level;
    logic [5:0]  tx_start_lvl;
    logic [10:0] tx_len;
    logic [10:0] tx_cnt;
    logic [10:0] rx_left;
    logic [13:0] tx_free;
    logic        rx_armed;
    logic        rx_blocked;
    logic        tx_drop;
    logic        tx_halt;
    logic        rx_pop;
    logic        tx_push;
    logic [15:0] tx_word;
    logic        tx_last;
    logic        tx_odd;
    logic        tx_abort;
    logic        tx_start;
    logic        rx_ready;
    logic        gap_drop;
    logic        operation_error_summary;
    logic        irq;
  } sys_t;

  sys_t        s, n;
  logic [15:0] ev;
  logic [15:0] clr;
  logic        req_new;
  logic [10:0] tx_rem;
  logic [5:0]  start_lvl;

  spi_xfer_if xfer ();

  link_engine u_link (
    .i_link_clk  (i_link_clk),
    .i_rst       (i_rst),
    .i_cs_n      (i_link_cs_n),
    .i_mosi      (i_link_mosi),
    .o_miso      (o_link_miso),
    .o_miso_oe_n (o_link_miso_oe_n),
    .x           (xfer.link)
  );

  assign xfer.ack_tgl = s.ack;
  assign xfer.rdata   = s.rdata;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    n          = s;
    n.rx_pop   = 1'b0;
    n.tx_push  = 1'b0;
    n.tx_abort = 1'b0;
    n.gap_drop = 1'b0;
    n.tx_free  = i_tx_free;
    // two-flop synchronisers for the link toggles
    n.req_s1   = xfer.req_tgl;
    n.req_s2   = s.req_s1;
    n.flt_s1   = xfer.fault_tgl;
    n.flt_s2   = s.flt_s1;
    n.flt_seen = s.flt_s2;
    req_new    = s.req_s2 != s.req_seen;
    tx_rem     = s.tx_len - s.tx_cnt;
    clr        = '0;
    ev         = '0;
    ev[BIT_READ_FAULT] = s.flt_s2 ^ s.flt_seen;
    ev[BIT_LINK_ERR]   = i_link_crc_err | i_hdr_parity_err | i_ctrl_mismatch_err;
    ev[BIT_UNDERRUN]   = i_tx_underrun & s.cfg[CFG_TX_CT];
    ev[BIT_TX_ECC]     = i_tx_len_ecc_err;
    ev[BIT_RX_ECC]     = i_rx_len_ecc_err;
    // gap shorter than the threshold: frame dropped and not counted
    if (i_rx_gap_strobe && (i_rx_gap_len < s.rx_gap)) begin
      n.gap_drop        = 1'b1;
      ev[BIT_SHORT_GAP] = 1'b1;
    end

    // register access from the link, one word per handshake
    if (req_new) begin
      n.req_seen = s.req_s2;
      n.ack      = ~s.ack;
      if (xfer.req_write) begin
        unique case (xfer.req_addr)
          OFF_ERR_FLAGS: clr = xfer.req_wdata & ERR_IMPL;
          OFF_ERR_MASK:  n.mask = xfer.req_wdata & ERR_IMPL;
          OFF_RX_LEVEL:  n.rx_level = xfer.req_wdata[6:0];
          OFF_TX_START:  n.tx_start_lvl = xfer.req_wdata[5:0];
          OFF_HOST_CFG:  n.cfg = xfer.req_wdata & CFG_IMPL;
          OFF_RX_GAP:    n.rx_gap = xfer.req_wdata;
          OFF_TX_LEN: begin
            // a new count marks the next start of frame
            n.tx_len  = xfer.req_wdata[10:0];
            n.tx_cnt  = '0;
            n.tx_drop = 1'b0;
          end
          OFF_TX_DATA: begin
            // writes past the byte count, or while discarding, are ignored
            if (!s.tx_halt && !s.tx_drop && (s.tx_cnt < s.tx_len)) begin
              if (s.tx_free == '0) begin
                // only the writer side frame is discarded; sending goes on
                n.tx_drop        = 1'b1;
                n.tx_abort       = 1'b1;
                ev[BIT_OVERFLOW] = 1'b1;
              end else begin
                n.tx_push = 1'b1;
                n.tx_word = xfer.req_wdata;
                n.tx_last = tx_rem <= 11'd2;
                n.tx_odd  = tx_rem == 11'd1;
                n.tx_cnt  = s.tx_cnt + ((tx_rem == 11'd1) ? 11'd1 : 11'd2);
              end
            end
          end
          default: ;
        endcase
      end else begin
        n.rdata = '0;
        unique case (xfer.req_addr)
          OFF_ERR_FLAGS: n.rdata = s.flags;
          OFF_ERR_MASK:  n.rdata = s.mask;
          OFF_RX_LEVEL:  n.rdata = {9'h000, s.rx_level};
          OFF_TX_LEN:    n.rdata = {5'h00, s.tx_len};
          OFF_TX_FREE:   n.rdata = {2'h0, s.tx_free};
          OFF_TX_START:  n.rdata = {10'h000, s.tx_start_lvl};
          OFF_HOST_CFG:  n.rdata = s.cfg;
          OFF_RX_GAP:    n.rdata = s.rx_gap;
          OFF_RX_LEN: begin
            // reading the length arms the data port for that frame
            n.rx_armed = 1'b0;
            n.rx_left  = '0;
            if (i_rx_head_avail && !s.rx_blocked) begin
              n.rdata    = {5'h00, i_rx_head_len};
              n.rx_left  = i_rx_head_len;
              n.rx_armed = i_rx_head_len != '0;
            end
          end
          OFF_RX_DATA: begin
            if (s.rx_armed && !s.rx_blocked && (s.rx_left != '0)) begin
              n.rx_pop = 1'b1;
              if (s.rx_left == 11'd1) begin
                n.rdata   = {i_rx_word[15:8], 8'h00};
                n.rx_left = '0;
              end else begin
                n.rdata   = i_rx_word;
                n.rx_left = s.rx_left - 11'd2;
              end
              n.rx_armed = n.rx_left != '0;
            end
          end
          default: ;
        endcase
      end
    end

    // fifo clears release the halts; a new error in the same cycle wins
    if (i_tx_fifo_flush) begin
      n.tx_halt = 1'b0;
      n.tx_drop = ev[BIT_OVERFLOW];
      n.tx_cnt  = n.tx_len;
    end
    if (i_rx_fifo_flush) begin
      n.rx_blocked = 1'b0;
      n.rx_armed   = 1'b0;
      n.rx_left    = '0;
    end
    if (ev[BIT_TX_ECC] || ev[BIT_UNDERRUN]) begin
      n.tx_halt = 1'b1;
    end
    if (ev[BIT_RX_ECC]) begin
      n.rx_blocked = 1'b1;
      n.rx_armed   = 1'b0;
    end

    // sticky flags: write one clears, a same-cycle event keeps the flag
    n.flags  = ((s.flags & ~clr) | ev) & ERR_IMPL;
    n.operation_error_summary = n.flags != '0;
    n.irq    = (n.flags & ~n.mask) != '0;

    // ready and start levels
    if (n.cfg[CFG_RX_CT]) begin
      n.rx_ready = (i_rx_level >= n.rx_level) || i_rx_eof_seen;
    end else begin
      n.rx_ready = i_rx_frames_avail;
    end
    n.rx_ready = n.rx_ready && !n.rx_blocked;
    // out-of-range start levels are pulled into the valid range
    start_lvl = n.tx_start_lvl;
    if (start_lvl < TX_START_MIN) begin
      start_lvl = TX_START_MIN;
    end else if (start_lvl > TX_START_MAX) begin
      start_lvl = TX_START_MAX;
    end
    if (n.cfg[CFG_TX_CT]) begin
      n.tx_start = (i_tx_buffered >= {8'h00, start_lvl}) || i_tx_frame_whole;
    end else begin
      n.tx_start = i_tx_frame_whole;
    end
    n.tx_start = n.tx_start && !n.tx_halt;
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s              <= '0;
      s.rx_level     <= RST_RX_LEVEL;
      s.tx_start_lvl <= RST_TX_START;
      s.tx_free      <= RST_TX_FREE;
      s.rx_gap       <= RST_RX_GAP;
    end else begin
      s <= n;
    end
  end

  assign o_rx_pop              = s.rx_pop;
  assign o_rx_gap_drop         = s.gap_drop;
  assign o_rx_ready            = s.rx_ready;
  assign o_tx_push             = s.tx_push;
  assign o_tx_word             = s.tx_word;
  assign o_tx_last             = s.tx_last;
  assign o_tx_last_odd         = s.tx_odd;
  assign o_tx_abort            = s.tx_abort;
  assign o_tx_start            = s.tx_start;
  assign o_tx_halt             = s.tx_halt;
  assign o_fwd_unknown_to_host = s.cfg[CFG_FWD_UNK];
  assign o_rx_low_first        = s.cfg[CFG_RX_LOW_1ST];
  assign o_operation_error_summary              = s.operation_error_summary;
  assign o_err_irq             = s.irq;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_flag_sticky: assert property ((clr == '0) |=> ((s.flags & $past(s.flags)) == $past(s.flags)))
    else $error("error flag dropped without a clear");
  a_set_wins: assert property ((ev != '0) |=> ((s.flags & $past(ev)) == ($past(ev) & ERR_IMPL)))
    else $error("error event lost");
  a_unr_cut_thru: assert property ($rose(s.flags[BIT_UNDERRUN]) |-> $past(s.cfg[CFG_TX_CT]) && s.tx_halt)
    else $error("underrun flag without cut-through or halt");
  a_ovf_discard: assert property ($rose(s.flags[BIT_OVERFLOW]) |-> s.tx_drop && s.tx_abort && !s.tx_push)
    else $error("overflow did not discard the frame");
  a_drop_no_push: assert property (s.tx_drop |=> !s.tx_push)
    else $error("write accepted while discarding");
  a_halt_holds: assert property (s.tx_halt && !i_tx_fifo_flush |=> s.tx_halt && !s.tx_start)
    else $error("tx halt released without flush");
  a_rx_withheld: assert property (s.rx_blocked |-> !s.rx_pop && !s.rx_ready)
    else $error("rx data passed while withheld");
  a_pop_counts: assert property (s.rx_pop |-> ($past(s.rx_left) - s.rx_left) inside {11'd1, 11'd2})
    else $error("pop without matching length step");
  a_no_read_past: assert property ((s.rx_left == '0) && !(req_new && !xfer.req_write) |=> !s.rx_pop)
    else $error("rx pop after frame end");
  a_push_bound: assert property (s.tx_push |-> s.tx_cnt <= s.tx_len && $past(s.tx_cnt) < s.tx_len)
    else $error("tx write beyond frame count");
  a_gap_drop: assert property (i_rx_gap_strobe && (i_rx_gap_len < s.rx_gap) |=> s.gap_drop && s.flags[BIT_SHORT_GAP])
    else $error("short gap frame not dropped");
  a_irq_gate: assert property (((s.flags & ~s.mask) == '0) |-> !s.irq)
    else $error("masked flag drives interrupt");
  a_op_summary: assert property ((s.flags != '0) |-> s.operation_error_summary)
    else $error("summary bit missing");

  c_rx_frame_done: cover property (s.rx_pop && (s.rx_left == '0));
  c_tx_overflow:   cover property ($rose(s.flags[BIT_OVERFLOW]));
  c_set_and_clear: cover property ((ev & clr) != '0);
  c_tx_last_odd:   cover property (s.tx_push && s.tx_odd);

endmodule

// ===== rtl/mac_host_pkg.sv
// constants shared by the host frame port and its serial link engine
// assumes a 16-bit register space reached over a 4-wire serial link
package mac_host_pkg;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_ERR_FLAGS  = 8'h04;
  localparam logic [7:0] OFF_ERR_MASK   = 8'h05;
  localparam logic [7:0] OFF_RX_LEN     = 8'h06;
  localparam logic [7:0] OFF_RX_DATA    = 8'h07;
  localparam logic [7:0] OFF_RX_LEVEL   = 8'h0c;
  localparam logic [7:0] OFF_TX_LEN     = 8'h0d;
  localparam logic [7:0] OFF_TX_DATA    = 8'h0e;
  localparam logic [7:0] OFF_TX_FREE    = 8'h0f;
  localparam logic [7:0] OFF_TX_START   = 8'h10;
  localparam logic [7:0] OFF_HOST_CFG   = 8'h11;
  localparam logic [7:0] OFF_RX_GAP     = 8'h95;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_READ_FAULT = 14;
  localparam int BIT_SHORT_GAP  = 5;
  localparam int BIT_UNDERRUN   = 4;
  localparam int BIT_OVERFLOW   = 3;
  localparam int BIT_LINK_ERR   = 2;
  localparam int BIT_TX_ECC     = 1;
  localparam int BIT_RX_ECC     = 0;
  localparam logic [15:0] ERR_IMPL = 16'h403f;
  localparam int CFG_FWD_UNK    = 5;
  localparam int CFG_RX_LOW_1ST = 2;
  localparam int CFG_TX_CT      = 1;
  localparam int CFG_RX_CT      = 0;
  localparam logic [15:0] CFG_IMPL = 16'h002f;
  localparam int HDR_WRITE_BIT  = 15;

  // ---------------------------------------------------------------------------
  // values after reset and limits
  // ---------------------------------------------------------------------------
  localparam logic [6:0]  RST_RX_LEVEL  = 7'h10;
  localparam logic [5:0]  RST_TX_START  = 6'h04;
  localparam logic [13:0] RST_TX_FREE   = 14'h0fff;
  localparam logic [15:0] RST_RX_GAP    = 16'h000a;
  localparam logic [5:0]  TX_START_MIN  = 6'h01;
  localparam logic [5:0]  TX_START_MAX  = 6'h1a;

  // ---------------------------------------------------------------------------
  // link framing
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  WORD_LAST_BIT = 4'hf;

endpackage

// ===== rtl/spi_xfer_if.sv
// word handshake between the serial link domain and the system domain
// assumes two-phase toggles; words stay stable while a toggle is pending
`timescale 1ns/1ps
interface spi_xfer_if;
  logic        req_tgl;
  logic        req_write;
  logic [7:0]  req_addr;
  logic [15:0] req_wdata;
  logic        fault_tgl;
  logic        ack_tgl;
  logic [15:0] rdata;

  modport link (output req_tgl, req_write, req_addr, req_wdata, fault_tgl,
                input  ack_tgl, rdata);
  modport core (input  req_tgl, req_write, req_addr, req_wdata, fault_tgl,
                output ack_tgl, rdata);
endinterface
